// file: common/dct_pkg.sv
// Package: register map, field layout, codes and state types of the dual 8-bit compare timer
package dct_pkg;

    // ------------------------------------------------------------------
    // Register map: address = {channel, index}
    // ------------------------------------------------------------------
    localparam logic [2:0] DCT_IDX_TCTL    = 3'h0;
    localparam logic [2:0] DCT_IDX_CSR     = 3'h1;
    localparam logic [2:0] DCT_IDX_CMPA    = 3'h2;
    localparam logic [2:0] DCT_IDX_CMPB    = 3'h3;
    localparam logic [2:0] DCT_IDX_CNT     = 3'h4;
    localparam logic [2:0] DCT_IDX_CCTL    = 3'h5;

    // ------------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------------
    localparam int         DCT_CSR_FLAG_LSB = 5;
    localparam int         DCT_TCTL_CLR_LSB = 3;
    localparam logic       DCT_CSR_RSVD     = 1'b1;
    localparam logic [2:0] DCT_CKS_STOP     = 3'h0;
    localparam logic [2:0] DCT_CKS_SYS      = 3'h1;
    localparam logic [2:0] DCT_CKS_CASC     = 3'h4;
    localparam logic [2:0] DCT_CKS_EXT_RISE = 3'h5;
    localparam logic [2:0] DCT_CKS_EXT_FALL = 3'h6;
    localparam logic [2:0] DCT_CKS_EXT_BOTH = 3'h7;
    localparam logic [1:0] DCT_CLR_NONE     = 2'h0;
    localparam logic [1:0] DCT_CLR_MATCH_A  = 2'h1;
    localparam logic [1:0] DCT_CLR_MATCH_B  = 2'h2;
    localparam logic [1:0] DCT_CLR_EXT      = 2'h3;
    localparam logic [1:0] DCT_OS_KEEP      = 2'h0;
    localparam logic [1:0] DCT_OS_LOW       = 2'h1;
    localparam logic [1:0] DCT_OS_HIGH      = 2'h2;
    localparam logic [1:0] DCT_OS_TOGGLE    = 2'h3;
    localparam logic [7:0] DCT_CNT_MAX      = 8'hFF;
    localparam logic [7:0] DCT_CNT_ZERO     = 8'h00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } dct_bus_req_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic [7:0] cmpa;
        logic [7:0] cmpb;
        logic [2:0] cks;
        logic [1:0] clr_sel;
        logic       rlvl;
        logic [2:0] flags;
        logic [3:0] os;
        logic       out;
        logic       pin;
        logic [2:0] clk_sync;
        logic [2:0] rst_sync;
    } dct_chan_t;

    typedef struct packed {
        dct_chan_t [1:0] ch;
        logic [7:0]      rdata;
    } dct_state_t;

    localparam dct_state_t DCT_STATE_RST = '0;

endpackage : dct_pkg

// file: core/dct_timer.sv
// Module: two-channel 8-bit compare timer with cascade modes
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
//
// Strobed register access and the address map were chosen for this implementation.
module dct_timer (
    input  logic                  i_clk,
    input  logic                  i_srst,
    input  dct_pkg::dct_bus_req_t i_bus,
    output logic [7:0]            o_rdata,
    input  logic [1:0]            i_ext_count_clk,
    input  logic [1:0]            i_ext_reset_in,
    output logic [1:0]            o_pulse_out
);

    // ------------------------------------------------------------------
    // State and decoded events
    // ------------------------------------------------------------------
    dct_pkg::dct_state_t s_q;
    dct_pkg::dct_state_t s_d;

    logic       mode16;
    logic       mcount;
    logic       stall;
    logic [1:0] base_tick;
    logic [1:0] tick;
    logic [1:0] ext_clr;
    logic [1:0] mat_a;
    logic [1:0] mat_b;
    logic [1:0] clr;
    logic [1:0] ovf;
    logic [1:0] cnt_wr;

    function automatic logic wr_at(input dct_pkg::dct_bus_req_t b, input logic chn, input logic [2:0] idx);
        wr_at = b.wr && (b.addr[3] == chn) && (b.addr[2:0] == idx);
    endfunction : wr_at

    function automatic logic [1:0] os_field(input logic [3:0] os, input logic sel_b);
        os_field = sel_b ? os[3:2] : os[1:0];
    endfunction : os_field

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [1:0] act_a;
        logic [1:0] act_b;
        logic       inh_a;
        logic       inh_b;
        logic       clr16;
        act_a = 2'h0;
        act_b = 2'h0;
        inh_a = 1'b0;
        inh_b = 1'b0;
        clr16 = 1'b0;
        s_d = s_q;
        base_tick = 2'h0;
        tick = 2'h0;
        ext_clr = 2'h0;
        mat_a = 2'h0;
        mat_b = 2'h0;
        clr = 2'h0;
        ovf = 2'h0;
        cnt_wr = 2'h0;

        // Mode decode
        mode16 = (s_q.ch[0].cks == dct_pkg::DCT_CKS_CASC) && (s_q.ch[1].cks != dct_pkg::DCT_CKS_CASC);
        mcount = (s_q.ch[1].cks == dct_pkg::DCT_CKS_CASC) && (s_q.ch[0].cks != dct_pkg::DCT_CKS_CASC);
        stall  = (s_q.ch[0].cks == dct_pkg::DCT_CKS_CASC) && (s_q.ch[1].cks == dct_pkg::DCT_CKS_CASC);

        for (int c = 0; c < 2; c++) begin
            // Pin synchronisers; stage 0 feeds only stage 1
            s_d.ch[c].clk_sync = {s_q.ch[c].clk_sync[1:0], i_ext_count_clk[c]};
            s_d.ch[c].rst_sync = {s_q.ch[c].rst_sync[1:0], i_ext_reset_in[c]};
            cnt_wr[c] = wr_at(i_bus, 1'(c), dct_pkg::DCT_IDX_CNT);
            case (s_q.ch[c].cks)
                dct_pkg::DCT_CKS_SYS: begin
                    base_tick[c] = 1'b1;
                end
                dct_pkg::DCT_CKS_EXT_RISE: begin
                    base_tick[c] = s_q.ch[c].clk_sync[1] & ~s_q.ch[c].clk_sync[2];
                end
                dct_pkg::DCT_CKS_EXT_FALL: begin
                    base_tick[c] = ~s_q.ch[c].clk_sync[1] & s_q.ch[c].clk_sync[2];
                end
                dct_pkg::DCT_CKS_EXT_BOTH: begin
                    base_tick[c] = s_q.ch[c].clk_sync[1] ^ s_q.ch[c].clk_sync[2];
                end
                default: begin
                    base_tick[c] = 1'b0;
                end
            endcase
            // External reset clear, edge or level
            if (s_q.ch[c].clr_sel == dct_pkg::DCT_CLR_EXT) begin
                ext_clr[c] = s_q.ch[c].rlvl ? s_q.ch[c].rst_sync[1]
                                            : (s_q.ch[c].rst_sync[1] & ~s_q.ch[c].rst_sync[2]);
            end
        end

        // Tick and match generation; matches fire on the tick seen at equality
        if (stall) begin
            tick = 2'h0;
        end else if (mode16) begin
            inh_a = wr_at(i_bus, 1'b0, dct_pkg::DCT_IDX_CMPA) || wr_at(i_bus, 1'b1, dct_pkg::DCT_IDX_CMPA);
            inh_b = wr_at(i_bus, 1'b0, dct_pkg::DCT_IDX_CMPB) || wr_at(i_bus, 1'b1, dct_pkg::DCT_IDX_CMPB);
            tick[1] = base_tick[1];
            tick[0] = base_tick[1] && (s_q.ch[1].cnt == dct_pkg::DCT_CNT_MAX);
            mat_a[0] = tick[1] && !inh_a && ({s_q.ch[0].cnt, s_q.ch[1].cnt} == {s_q.ch[0].cmpa, s_q.ch[1].cmpa});
            mat_b[0] = tick[1] && !inh_b && ({s_q.ch[0].cnt, s_q.ch[1].cnt} == {s_q.ch[0].cmpb, s_q.ch[1].cmpb});
            mat_a[1] = tick[1] && !wr_at(i_bus, 1'b1, dct_pkg::DCT_IDX_CMPA) && (s_q.ch[1].cnt == s_q.ch[1].cmpa);
            mat_b[1] = tick[1] && !wr_at(i_bus, 1'b1, dct_pkg::DCT_IDX_CMPB) && (s_q.ch[1].cnt == s_q.ch[1].cmpb);
            clr16 = ((s_q.ch[0].clr_sel == dct_pkg::DCT_CLR_MATCH_A) && mat_a[0])
                 || ((s_q.ch[0].clr_sel == dct_pkg::DCT_CLR_MATCH_B) && mat_b[0])
                 || ext_clr[0];
            clr = {clr16, clr16};
            ovf[1] = tick[1] && (s_q.ch[1].cnt == dct_pkg::DCT_CNT_MAX) && !clr16;
            ovf[0] = ovf[1] && (s_q.ch[0].cnt == dct_pkg::DCT_CNT_MAX);
        end else begin
            tick[0] = base_tick[0];
            for (int c = 0; c < 2; c++) begin
                if (c == 1) begin
                    tick[1] = mcount ? mat_a[0] : base_tick[1];
                end
                mat_a[c] = tick[c] && !wr_at(i_bus, 1'(c), dct_pkg::DCT_IDX_CMPA)
                        && (s_q.ch[c].cnt == s_q.ch[c].cmpa);
                mat_b[c] = tick[c] && !wr_at(i_bus, 1'(c), dct_pkg::DCT_IDX_CMPB)
                        && (s_q.ch[c].cnt == s_q.ch[c].cmpb);
                clr[c] = ((s_q.ch[c].clr_sel == dct_pkg::DCT_CLR_MATCH_A) && mat_a[c])
                      || ((s_q.ch[c].clr_sel == dct_pkg::DCT_CLR_MATCH_B) && mat_b[c])
                      || ext_clr[c];
                ovf[c] = tick[c] && (s_q.ch[c].cnt == dct_pkg::DCT_CNT_MAX) && !clr[c];
            end
        end

        for (int c = 0; c < 2; c++) begin
            // Counter: clear beats write, write beats increment
            if (clr[c]) begin
                s_d.ch[c].cnt = dct_pkg::DCT_CNT_ZERO;
            end else if (cnt_wr[c]) begin
                s_d.ch[c].cnt = i_bus.wdata;
            end else if (tick[c]) begin
                s_d.ch[c].cnt = s_q.ch[c].cnt + 8'h01;
            end
            // Control registers
            if (wr_at(i_bus, 1'(c), dct_pkg::DCT_IDX_TCTL)) begin
                s_d.ch[c].cks     = i_bus.wdata[2:0];
                s_d.ch[c].clr_sel = i_bus.wdata[dct_pkg::DCT_TCTL_CLR_LSB +: 2];
            end
            if (wr_at(i_bus, 1'(c), dct_pkg::DCT_IDX_CCTL)) begin
                s_d.ch[c].rlvl = i_bus.wdata[0];
            end
            if (wr_at(i_bus, 1'(c), dct_pkg::DCT_IDX_CMPA)) begin
                s_d.ch[c].cmpa = i_bus.wdata;
            end
            if (wr_at(i_bus, 1'(c), dct_pkg::DCT_IDX_CMPB)) begin
                s_d.ch[c].cmpb = i_bus.wdata;
            end
            // Flags: zero clears, set wins over clear
            if (wr_at(i_bus, 1'(c), dct_pkg::DCT_IDX_CSR)) begin
                s_d.ch[c].os    = i_bus.wdata[3:0];
                s_d.ch[c].flags = s_q.ch[c].flags & i_bus.wdata[dct_pkg::DCT_CSR_FLAG_LSB +: 3];
            end
            s_d.ch[c].flags = s_d.ch[c].flags | {mat_b[c], mat_a[c], ovf[c]};
            // Output action with priority toggle, high, low, keep
            act_a = mat_a[c] ? os_field(s_q.ch[c].os, 1'b0) : dct_pkg::DCT_OS_KEEP;
            act_b = mat_b[c] ? os_field(s_q.ch[c].os, 1'b1) : dct_pkg::DCT_OS_KEEP;
            if (act_a == dct_pkg::DCT_OS_TOGGLE || act_b == dct_pkg::DCT_OS_TOGGLE) begin
                s_d.ch[c].out = ~s_q.ch[c].out;
            end else if (act_a == dct_pkg::DCT_OS_HIGH || act_b == dct_pkg::DCT_OS_HIGH) begin
                s_d.ch[c].out = 1'b1;
            end else if (act_a == dct_pkg::DCT_OS_LOW || act_b == dct_pkg::DCT_OS_LOW) begin
                s_d.ch[c].out = 1'b0;
            end
            s_d.ch[c].pin = (s_d.ch[c].os != 4'h0) && s_d.ch[c].out;
        end

        // Read data, one cycle after the strobe
        s_d.rdata = 8'h00;
        if (i_bus.rd) begin
            case (i_bus.addr[2:0])
                dct_pkg::DCT_IDX_TCTL: s_d.rdata = {3'h0, s_q.ch[i_bus.addr[3]].clr_sel, s_q.ch[i_bus.addr[3]].cks};
                dct_pkg::DCT_IDX_CSR:  s_d.rdata = {s_q.ch[i_bus.addr[3]].flags, dct_pkg::DCT_CSR_RSVD,
                                                    s_q.ch[i_bus.addr[3]].os};
                dct_pkg::DCT_IDX_CMPA: s_d.rdata = s_q.ch[i_bus.addr[3]].cmpa;
                dct_pkg::DCT_IDX_CMPB: s_d.rdata = s_q.ch[i_bus.addr[3]].cmpb;
                dct_pkg::DCT_IDX_CNT:  s_d.rdata = s_q.ch[i_bus.addr[3]].cnt;
                dct_pkg::DCT_IDX_CCTL: s_d.rdata = {7'h00, s_q.ch[i_bus.addr[3]].rlvl};
                default:               s_d.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_q <= dct_pkg::DCT_STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata     = s_q.rdata;
    assign o_pulse_out = {s_q.ch[1].pin, s_q.ch[0].pin};

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic any_wr;
    assign any_wr = i_bus.wr;

    sequence low_carry_s;
        mode16 && tick[1] && (s_q.ch[1].cnt == dct_pkg::DCT_CNT_MAX) && !clr[0] && !any_wr;
    endsequence

    sequence cascade_hit_s;
        mcount && mat_a[0] && !clr[1] && !any_wr;
    endsequence

    flag_b_set_a: assert property (@(posedge i_clk) disable iff (i_srst)
        mat_b[0] |=> s_q.ch[0].flags[2])
        else $error("match B did not set flag");

    flag_one_write_a: assert property (@(posedge i_clk) disable iff (i_srst)
        wr_at(i_bus, 1'b0, dct_pkg::DCT_IDX_CSR) && !mat_a[0] && !mat_b[0] && !ovf[0]
        |=> (s_q.ch[0].flags & ~$past(s_q.ch[0].flags)) == 3'h0)
        else $error("written one set a flag");

    wrap_flag_a: assert property (@(posedge i_clk) disable iff (i_srst)
        tick[0] && !mode16 && !clr[0] && !cnt_wr[0] && s_q.ch[0].cnt == dct_pkg::DCT_CNT_MAX
        |=> s_q.ch[0].flags[0] && s_q.ch[0].cnt == dct_pkg::DCT_CNT_ZERO)
        else $error("wrap missed overflow");

    clear_wins_a: assert property (@(posedge i_clk) disable iff (i_srst)
        clr[1] && cnt_wr[1] |=> s_q.ch[1].cnt == dct_pkg::DCT_CNT_ZERO)
        else $error("write beat clear");

    match_a_clear_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !mode16 && s_q.ch[0].clr_sel == dct_pkg::DCT_CLR_MATCH_A && mat_a[0]
        |=> s_q.ch[0].cnt == dct_pkg::DCT_CNT_ZERO)
        else $error("match A did not clear");

    pin_cause_a: assert property (@(posedge i_clk) disable iff (i_srst)
        $changed(s_q.ch[0].out) |-> $past(mat_a[0] || mat_b[0]))
        else $error("output moved without match");

    pin_disabled_a: assert property (@(posedge i_clk) disable iff (i_srst)
        s_q.ch[1].os == 4'h0 |-> o_pulse_out[1] == 1'b0)
        else $error("pin high while disabled");

    carry_16_a: assert property (@(posedge i_clk) disable iff (i_srst)
        low_carry_s |=> s_q.ch[0].cnt == $past(s_q.ch[0].cnt) + 8'h01)
        else $error("upper byte missed carry");

    stall_stop_a: assert property (@(posedge i_clk) disable iff (i_srst)
        stall && !any_wr && ext_clr == 2'h0 |=> $stable(s_q.ch[0].cnt) && $stable(s_q.ch[1].cnt))
        else $error("counter ran in stall");

    match_count_a: assert property (@(posedge i_clk) disable iff (i_srst)
        cascade_hit_s |=> s_q.ch[1].cnt == $past(s_q.ch[1].cnt) + 8'h01)
        else $error("channel 1 missed match count");

    toggle_prio_a: assert property (@(posedge i_clk) disable iff (i_srst)
        mat_a[0] && mat_b[0] && (s_q.ch[0].os[3:2] == dct_pkg::DCT_OS_TOGGLE || s_q.ch[0].os[1:0] == dct_pkg::DCT_OS_TOGGLE)
        |=> s_q.ch[0].out != $past(s_q.ch[0].out))
        else $error("toggle lost priority");

endmodule : dct_timer

// file: dv/dct_far_model.sv
// Far-side model: external count clocks and counter reset inputs
module dct_far_model (
    input  logic       i_clk,
    output logic [1:0] o_ext_count_clk,
    output logic [1:0] o_ext_reset_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_ext_count_clk = 2'h0;
        o_ext_reset_in  = 2'h0;
    end

    // ------------------------------------------------------------------
    // Count pulses, three states high and three low
    // ------------------------------------------------------------------
    task automatic pulse(input logic [1:0] mask, input int n);
        @(posedge i_clk);
        repeat (n) begin
            o_ext_count_clk <= o_ext_count_clk | mask;
            repeat (3) @(posedge i_clk);
            o_ext_count_clk <= o_ext_count_clk & ~mask;
            repeat (3) @(posedge i_clk);
        end
    endtask : pulse

    // ------------------------------------------------------------------
    // Reset level, held many states by the caller
    // ------------------------------------------------------------------
    task automatic hold_reset(input logic [1:0] mask, input logic lvl);
        @(posedge i_clk);
        o_ext_reset_in <= lvl ? (o_ext_reset_in | mask) : (o_ext_reset_in & ~mask);
    endtask : hold_reset
endmodule : dct_far_model

// file: dv/tb_top.sv
// Testbench: registers, pin actions, clears and cascade of the compare timer
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  clk;
    logic                  srst;
    dct_pkg::dct_bus_req_t bus;
    logic [7:0]            rdata;
    logic [1:0]            ext_clk;
    logic [1:0]            ext_rst;
    logic [1:0]            pulse;
    logic [7:0]            v;
    int                    mismatches;
    int                    compares;

    dct_timer i_dct_timer (
        .i_clk           (clk),
        .i_srst          (srst),
        .i_bus           (bus),
        .o_rdata         (rdata),
        .i_ext_count_clk (ext_clk),
        .i_ext_reset_in  (ext_rst),
        .o_pulse_out     (pulse)
    );

    dct_far_model i_dct_far_model (
        .i_clk           (clk),
        .o_ext_count_clk (ext_clk),
        .o_ext_reset_in  (ext_rst)
    );

    initial clk = 1'b0;
    always #10 clk = ~clk;

    // ------------------------------------------------------------------
    // Bus, compare and closing tasks
    // ------------------------------------------------------------------
    task automatic end_sim;
        $display("Counts: mismatches %0d, compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic ch, input logic [2:0] idx, input logic [7:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: {ch, idx}, wdata: d};
        @(posedge clk);
        bus <= '0;
        #1;
    endtask : wr

    task automatic rd(input logic ch, input logic [2:0] idx, output logic [7:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: {ch, idx}, wdata: 8'h00};
        @(posedge clk);
        bus <= '0;
        #1;
        d = rdata;
    endtask : rd

    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
    endtask : waitc

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd(1'b0, dct_pkg::DCT_IDX_CSR, v);
        chk("csr0_rst", 8'h10, v);
        rd(1'b1, dct_pkg::DCT_IDX_CNT, v);
        chk("cnt1_rst", 8'h00, v);
        wr(1'b0, 3'h7, 8'hFF);
        rd(1'b0, 3'h6, v);
        chk("unmapped", 8'h00, v);
        rd(1'b0, dct_pkg::DCT_IDX_TCTL, v);
        chk("tctl0_rst", 8'h00, v);
    endtask : t_reset

    task automatic t_pulse;
        wr(1'b0, dct_pkg::DCT_IDX_CMPA, 8'h03);
        wr(1'b0, dct_pkg::DCT_IDX_CSR, 8'h02);
        chk("pin_pre", 8'h00, {6'h00, pulse});
        wr(1'b0, dct_pkg::DCT_IDX_TCTL, 8'h09);
        waitc(20);
        wr(1'b0, dct_pkg::DCT_IDX_TCTL, 8'h08);
        rd(1'b0, dct_pkg::DCT_IDX_CNT, v);
        chk("cnt_le_cmpa", 8'h01, {7'h00, v <= 8'h03});
        rd(1'b0, dct_pkg::DCT_IDX_CSR, v);
        chk("flags_ab", 8'hD2, v);
        chk("pin_high", 8'h01, {6'h00, pulse});
        wr(1'b0, dct_pkg::DCT_IDX_CSR, 8'hE2);
        rd(1'b0, dct_pkg::DCT_IDX_CSR, v);
        chk("flags_w1", 8'hD2, v);
        wr(1'b0, dct_pkg::DCT_IDX_CSR, 8'h02);
        rd(1'b0, dct_pkg::DCT_IDX_CSR, v);
        chk("flags_w0", 8'h12, v);
    endtask : t_pulse

    task automatic t_toggle_wrap;
        wr(1'b0, dct_pkg::DCT_IDX_TCTL, 8'h00);
        wr(1'b0, dct_pkg::DCT_IDX_CMPA, 8'hFC);
        wr(1'b0, dct_pkg::DCT_IDX_CMPB, 8'hFC);
        wr(1'b0, dct_pkg::DCT_IDX_CSR, 8'h0E);
        wr(1'b0, dct_pkg::DCT_IDX_CNT, 8'hFA);
        wr(1'b0, dct_pkg::DCT_IDX_TCTL, 8'h01);
        waitc(12);
        wr(1'b0, dct_pkg::DCT_IDX_TCTL, 8'h00);
        rd(1'b0, dct_pkg::DCT_IDX_CSR, v);
        chk("flags_wrap", 8'hFE, v);
        chk("pin_toggle", 8'h00, {6'h00, pulse});
        rd(1'b0, dct_pkg::DCT_IDX_CNT, v);
        chk("cnt_wrapped", 8'h01, {7'h00, v >= 8'h02 && v <= 8'h0F});
    endtask : t_toggle_wrap

    task automatic t_ext_reset;
        wr(1'b1, dct_pkg::DCT_IDX_CCTL, 8'h01);
        wr(1'b1, dct_pkg::DCT_IDX_TCTL, 8'h19);
        i_dct_far_model.hold_reset(2'h2, 1'b1);
        waitc(10);
        wr(1'b1, dct_pkg::DCT_IDX_CNT, 8'h55);
        rd(1'b1, dct_pkg::DCT_IDX_CNT, v);
        chk("cnt_held", 8'h00, v);
        i_dct_far_model.hold_reset(2'h2, 1'b0);
        waitc(10);
        rd(1'b1, dct_pkg::DCT_IDX_CNT, v);
        chk("cnt_runs", 8'h01, {7'h00, v != 8'h00});
        wr(1'b1, dct_pkg::DCT_IDX_CCTL, 8'h00);
        waitc(40);
        i_dct_far_model.hold_reset(2'h2, 1'b1);
        waitc(6);
        rd(1'b1, dct_pkg::DCT_IDX_CNT, v);
        chk("cnt_edge_clr", 8'h01, {7'h00, v != 8'h00 && v < 8'h10});
        i_dct_far_model.hold_reset(2'h2, 1'b0);
    endtask : t_ext_reset

    task automatic t_ext_count;
        wr(1'b1, dct_pkg::DCT_IDX_TCTL, 8'h00);
        wr(1'b1, dct_pkg::DCT_IDX_CNT, 8'h00);
        wr(1'b1, dct_pkg::DCT_IDX_TCTL, 8'h05);
        i_dct_far_model.pulse(2'h2, 5);
        waitc(6);
        rd(1'b1, dct_pkg::DCT_IDX_CNT, v);
        chk("cnt_ext", 8'h05, v);
        wr(1'b1, dct_pkg::DCT_IDX_TCTL, 8'h06);
        i_dct_far_model.pulse(2'h2, 2);
        waitc(6);
        wr(1'b1, dct_pkg::DCT_IDX_TCTL, 8'h07);
        i_dct_far_model.pulse(2'h2, 2);
        waitc(6);
        rd(1'b1, dct_pkg::DCT_IDX_CNT, v);
        chk("cnt_ext_edges", 8'h0B, v);
        wr(1'b0, dct_pkg::DCT_IDX_CNT, 8'h00);
        wr(1'b0, dct_pkg::DCT_IDX_CMPA, 8'h01);
        wr(1'b0, dct_pkg::DCT_IDX_TCTL, 8'h0D);
        wr(1'b1, dct_pkg::DCT_IDX_CNT, 8'h00);
        wr(1'b1, dct_pkg::DCT_IDX_TCTL, 8'h04);
        i_dct_far_model.pulse(2'h1, 8);
        waitc(6);
        rd(1'b0, dct_pkg::DCT_IDX_CNT, v);
        chk("cnt0_clr_a", 8'h00, v);
        rd(1'b1, dct_pkg::DCT_IDX_CNT, v);
        chk("cnt1_matches", 8'h04, v);
    endtask : t_ext_count

    task automatic t_clear_b;
        wr(1'b0, dct_pkg::DCT_IDX_TCTL, 8'h00);
        wr(1'b0, dct_pkg::DCT_IDX_CNT, 8'h00);
        wr(1'b0, dct_pkg::DCT_IDX_CMPB, 8'h05);
        wr(1'b0, dct_pkg::DCT_IDX_CSR, 8'h0E);
        wr(1'b0, dct_pkg::DCT_IDX_TCTL, 8'h11);
        waitc(20);
        wr(1'b0, dct_pkg::DCT_IDX_TCTL, 8'h10);
        rd(1'b0, dct_pkg::DCT_IDX_CNT, v);
        chk("cnt_le_cmpb", 8'h01, {7'h00, v <= 8'h05});
        rd(1'b0, dct_pkg::DCT_IDX_CSR, v);
        chk("flags_clr_b", 8'hDE, v);
    endtask : t_clear_b

    task automatic t_cascade16;
        wr(1'b0, dct_pkg::DCT_IDX_TCTL, 8'h00);
        wr(1'b1, dct_pkg::DCT_IDX_TCTL, 8'h00);
        wr(1'b0, dct_pkg::DCT_IDX_CSR, 8'h0E);
        wr(1'b1, dct_pkg::DCT_IDX_CSR, 8'h00);
        wr(1'b0, dct_pkg::DCT_IDX_CNT, 8'h00);
        wr(1'b1, dct_pkg::DCT_IDX_CNT, 8'hFE);
        wr(1'b1, dct_pkg::DCT_IDX_CMPA, 8'hFE);
        wr(1'b1, dct_pkg::DCT_IDX_TCTL, 8'h0D);
        wr(1'b0, dct_pkg::DCT_IDX_TCTL, 8'h04);
        i_dct_far_model.pulse(2'h2, 3);
        waitc(6);
        rd(1'b0, dct_pkg::DCT_IDX_CNT, v);
        chk("cnt16_hi", 8'h01, v);
        rd(1'b1, dct_pkg::DCT_IDX_CNT, v);
        chk("cnt16_lo", 8'h01, v);
        rd(1'b1, dct_pkg::DCT_IDX_CSR, v);
        chk("flags16_lo", 8'hF0, v);
        rd(1'b0, dct_pkg::DCT_IDX_CSR, v);
        chk("flags16_hi", 8'h1E, v);
        wr(1'b1, dct_pkg::DCT_IDX_TCTL, 8'h04);
        i_dct_far_model.pulse(2'h2, 2);
        waitc(4);
        rd(1'b0, dct_pkg::DCT_IDX_CNT, v);
        chk("stall_hi", 8'h01, v);
        rd(1'b1, dct_pkg::DCT_IDX_CNT, v);
        chk("stall_lo", 8'h01, v);
    endtask : t_cascade16

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        srst = 1'b1;
        bus = '0;
        mismatches = 0;
        compares = 0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_pulse();
        t_toggle_wrap();
        t_ext_reset();
        t_ext_count();
        t_clear_b();
        t_cascade16();
        end_sim();
    end

    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        end_sim();
    end
endmodule : tb_top
